// >>> common/gpt_pkg.sv
// Package for the general-purpose timer group: register map, fields, reset values
package gpt_pkg;
   localparam int         MAIN_W         = 16;
   localparam int         SMALL_W        = 8;
   localparam int         NUM_CH         = 5;
   localparam int         PRESC_W        = 8;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF       = 8'h00;
   localparam logic [7:0] STAT_OFF       = 8'h04;
   localparam logic [7:0] MASK_OFF       = 8'h08;
   localparam logic [7:0] MPRE_OFF       = 8'h0C;
   localparam logic [7:0] MPER_OFF       = 8'h10;
   localparam logic [7:0] MCNT_OFF       = 8'h14;
   localparam logic [7:0] CHMODE_OFF     = 8'h18;
   localparam logic [7:0] CHVAL_OFF      = 8'h1C;
   localparam logic [7:0] SA_CFG_OFF     = 8'h30;
   localparam logic [7:0] SB_CFG_OFF     = 8'h34;
   localparam logic [7:0] SCNT_OFF       = 8'h38;
   // Control fields
   localparam int         CTRL_MAIN_EN   = 0;
   localparam int         CTRL_SA_EN     = 1;
   localparam int         CTRL_SB_EN     = 2;
   localparam int         CTRL_IR_EN     = 3;
   // Status bits: 0 main period, 1..5 capture, 6 small A period, 7 small B period
   localparam int         ST_W           = 8;
   localparam int         ST_MAIN        = 0;
   localparam int         ST_CAP0        = 1;
   localparam int         ST_SA          = 6;
   localparam int         ST_SB          = 7;
   // Small timer config word: [7:0] prescale, [15:8] period, [23:16] compare
   localparam int         SCFG_PER_LSB   = 8;
   localparam int         SCFG_CMP_LSB   = 16;
   // Reset values
   localparam logic [15:0] MPER_RST      = 16'hFFFF;
   localparam logic [7:0]  SPER_RST      = 8'hFF;
   localparam logic [7:0]  PRE_RST       = 8'h00;
   // Minimum capture pulse on the pin, in tenths of system clock periods
   localparam int         CAP_MIN_TENTHS = 15;
endpackage : gpt_pkg

// >>> src/gpt_small.sv
// Eight-bit timer with prescaler, period and one PWM compare channel
`timescale 1ns/10ps
`default_nettype none
module gpt_small #(
   parameter int W = 8
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         enable,
   input  wire logic [7:0]   prescale,
   input  wire logic [W-1:0] period,
   input  wire logic [W-1:0] compare,
   output logic [W-1:0]      count,
   output logic              period_evt,
   output logic              pwm
);
   import gpt_pkg::*;

   typedef struct packed {
      logic [7:0]   pre;
      logic [W-1:0] cnt;
      logic         evt;
      logic         pwm;
   } gpt_small_st_t;

   gpt_small_st_t st_reg;
   gpt_small_st_t st_next;

   always_comb begin
      logic tick;
      tick    = 1'b0;
      st_next = st_reg;
      st_next.evt = 1'b0;
      if (!enable) begin
         st_next.pre = '0;
         st_next.cnt = '0;
      end else if (st_reg.pre >= prescale) begin
         st_next.pre = '0;
         tick = 1'b1;
      end else begin
         st_next.pre = st_reg.pre + 8'h01;
      end
      if (tick) begin
         if (st_reg.cnt >= period) begin
            st_next.cnt = '0;
            st_next.evt = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
         end
      end
      st_next.pwm = enable && (st_next.cnt < compare);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign count      = st_reg.cnt;
   assign period_evt = st_reg.evt;
   assign pwm        = st_reg.pwm;

   a_small_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      period_evt |-> count == '0)
      else $error("small timer period event without wrap to zero");
endmodule : gpt_small
`default_nettype wire

// >>> src/gpt_top.sv
// General-purpose timer group: 16-bit five-channel timer, two 8-bit timers, APB registers
`timescale 1ns/10ps
`default_nettype none
module gpt_top #(
   parameter int NCH = gpt_pkg::NUM_CH
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [NCH-1:0]    cap_in,
   output logic [NCH-1:0]         main_out,
   output logic                   small_a_out,
   output logic                   small_b_out,
   output logic                   irq
);
   import gpt_pkg::*;

   typedef struct packed {
      logic [3:0]               ctrl;
      logic [ST_W-1:0]          stat;
      logic [ST_W-1:0]          mask;
      logic [PRESC_W-1:0]       mpre;
      logic [MAIN_W-1:0]        mper;
      logic [NCH-1:0]           chmode;   // 1 = capture
      logic [NCH-1:0][1:0]      chedge;   // bit0 rising, bit1 falling
      logic [NCH-1:0][MAIN_W-1:0] chval;
      logic [23:0]              sa_cfg;
      logic [23:0]              sb_cfg;
      logic [PRESC_W-1:0]       mpre_cnt;
      logic [MAIN_W-1:0]        mcnt;
      logic [NCH-1:0]           sync1;
      logic [NCH-1:0]           sync2;
      logic [NCH-1:0]           sync3;
      logic                     mevt;
      logic [NCH-1:0]           pwm;
      logic [31:0]              rdata;
   } gpt_st_t;

   gpt_st_t st_reg;
   gpt_st_t st_next;

   logic [SMALL_W-1:0] sa_cnt;
   logic [SMALL_W-1:0] sb_cnt;
   logic               sa_evt;
   logic               sb_evt;
   logic               sa_pwm;
   logic               sb_pwm;

   // Byte-lane merge for 32-bit register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Channel value registers sit one word apart from the first channel's offset
   function automatic logic is_chval(input logic [7:0] a, input int ch);
      return a == 8'(int'(CHVAL_OFF) + 4 * ch);
   endfunction : is_chval

   gpt_small #(.W(SMALL_W)) u_small_a (
      .pclk       (pclk),
      .presetn    (presetn),
      .enable     (st_reg.ctrl[CTRL_SA_EN]),
      .prescale   (st_reg.sa_cfg[PRESC_W-1:0]),
      .period     (st_reg.sa_cfg[SCFG_PER_LSB +: SMALL_W]),
      .compare    (st_reg.sa_cfg[SCFG_CMP_LSB +: SMALL_W]),
      .count      (sa_cnt),
      .period_evt (sa_evt),
      .pwm        (sa_pwm)
   );

   gpt_small #(.W(SMALL_W)) u_small_b (
      .pclk       (pclk),
      .presetn    (presetn),
      .enable     (st_reg.ctrl[CTRL_SB_EN]),
      .prescale   (st_reg.sb_cfg[PRESC_W-1:0]),
      .period     (st_reg.sb_cfg[SCFG_PER_LSB +: SMALL_W]),
      .compare    (st_reg.sb_cfg[SCFG_CMP_LSB +: SMALL_W]),
      .count      (sb_cnt),
      .period_evt (sb_evt),
      .pwm        (sb_pwm)
   );

   // Reads are taken in the setup cycle so prdata is settled for the whole access cycle
   wire logic apb_wr = psel && penable && pwrite;
   wire logic apb_rd = psel && !penable && !pwrite;
   wire logic mapped = (paddr[1:0] == 2'b00) && (paddr <= SCNT_OFF);

   always_comb begin
      logic             tick;
      logic [ST_W-1:0]  ev;
      logic [NCH-1:0]   rise;
      logic [NCH-1:0]   fall;
      logic [31:0]      w;
      tick = 1'b0;
      ev   = '0;
      rise = '0;
      fall = '0;
      w    = '0;
      st_next = st_reg;
      st_next.mevt = 1'b0;

      // Only the second and third flops feed edge detection; the first only feeds the second
      st_next.sync1 = cap_in;
      st_next.sync2 = st_reg.sync1;
      st_next.sync3 = st_reg.sync2;
      rise = st_reg.sync2 & ~st_reg.sync3;
      fall = ~st_reg.sync2 & st_reg.sync3;

      // Main tick source: own prescaler, or small timer A periods in IR mode
      if (!st_reg.ctrl[CTRL_MAIN_EN]) begin
         st_next.mpre_cnt = '0;
         st_next.mcnt     = '0;
      end else if (st_reg.ctrl[CTRL_IR_EN]) begin
         tick = sa_evt;
      end else if (st_reg.mpre_cnt >= st_reg.mpre) begin
         st_next.mpre_cnt = '0;
         tick = 1'b1;
      end else begin
         st_next.mpre_cnt = st_reg.mpre_cnt + 8'h01;
      end
      // A period lowered below the count wraps at once instead of running to overflow
      if (tick) begin
         if (st_reg.mcnt >= st_reg.mper) begin
            st_next.mcnt = '0;
            st_next.mevt = 1'b1;
            ev[ST_MAIN]  = 1'b1;
         end else begin
            st_next.mcnt = st_reg.mcnt + 16'h0001;
         end
      end

      for (int c = 0; c < NCH; c++) begin
         if (st_reg.chmode[c]) begin
            st_next.pwm[c] = 1'b0;
            if ((rise[c] && st_reg.chedge[c][0]) || (fall[c] && st_reg.chedge[c][1])) begin
               st_next.chval[c]  = st_reg.mcnt;
               ev[ST_CAP0 + c]   = 1'b1;
            end
         end
      end
      // Small timer events reach status one cycle after their counters wrap
      ev[ST_SA] = sa_evt;
      ev[ST_SB] = sb_evt;

      // Register access; a read of status clears it, but new events win
      st_next.rdata = '0;
      if (apb_rd && mapped) begin
         case (paddr)
            CTRL_OFF:   st_next.rdata = 32'(st_reg.ctrl);
            STAT_OFF:   st_next.rdata = 32'(st_reg.stat);
            MASK_OFF:   st_next.rdata = 32'(st_reg.mask);
            MPRE_OFF:   st_next.rdata = 32'(st_reg.mpre);
            MPER_OFF:   st_next.rdata = 32'(st_reg.mper);
            MCNT_OFF:   st_next.rdata = 32'(st_reg.mcnt);
            CHMODE_OFF: st_next.rdata = 32'({st_reg.chedge, st_reg.chmode});
            SA_CFG_OFF: st_next.rdata = 32'(st_reg.sa_cfg);
            SB_CFG_OFF: st_next.rdata = 32'(st_reg.sb_cfg);
            SCNT_OFF:   st_next.rdata = {16'h0000, sb_cnt, sa_cnt};
            default: begin
               for (int c = 0; c < NCH; c++) begin
                  if (is_chval(paddr, c)) begin
                     st_next.rdata = 32'(st_reg.chval[c]);
                  end
               end
            end
         endcase
         if (paddr == STAT_OFF) begin
            st_next.stat = '0;
         end
      end
      if (apb_wr && mapped) begin
         case (paddr)
            CTRL_OFF: begin
               w = merge(32'(st_reg.ctrl), pwdata, pstrb);
               st_next.ctrl = w[3:0];
            end
            MASK_OFF: begin
               w = merge(32'(st_reg.mask), pwdata, pstrb);
               st_next.mask = w[ST_W-1:0];
            end
            MPRE_OFF: begin
               w = merge(32'(st_reg.mpre), pwdata, pstrb);
               st_next.mpre = w[PRESC_W-1:0];
            end
            MPER_OFF: begin
               w = merge(32'(st_reg.mper), pwdata, pstrb);
               st_next.mper = w[MAIN_W-1:0];
            end
            CHMODE_OFF: begin
               w = merge(32'({st_reg.chedge, st_reg.chmode}), pwdata, pstrb);
               {st_next.chedge, st_next.chmode} = w[3*NCH-1:0];
            end
            SA_CFG_OFF: begin
               w = merge(32'(st_reg.sa_cfg), pwdata, pstrb);
               st_next.sa_cfg = w[23:0];
            end
            SB_CFG_OFF: begin
               w = merge(32'(st_reg.sb_cfg), pwdata, pstrb);
               st_next.sb_cfg = w[23:0];
            end
            default: begin
               for (int c = 0; c < NCH; c++) begin
                  if (is_chval(paddr, c)) begin
                     w = merge(32'(st_reg.chval[c]), pwdata, pstrb);
                     st_next.chval[c] = w[MAIN_W-1:0];
                  end
               end
            end
         endcase
      end
      // PWM levels use this cycle's writes, so an enable or new compare shows at once
      for (int c = 0; c < NCH; c++) begin
         if (!st_reg.chmode[c]) begin
            st_next.pwm[c] = st_next.ctrl[CTRL_MAIN_EN] &&
                             (st_next.mcnt < st_next.chval[c]);
         end
      end
      st_next.stat = st_next.stat | ev;
   end

   // Periods reset to full scale, so a timer enabled before setup still wraps sanely
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg        <= '0;
         st_reg.mper   <= MPER_RST;
         st_reg.mpre   <= PRE_RST;
         st_reg.sa_cfg <= {8'h00, SPER_RST, PRE_RST};
         st_reg.sb_cfg <= {8'h00, SPER_RST, PRE_RST};
      end else begin
         st_reg <= st_next;
      end
   end

   // Zero wait states: read data is captured in setup and presented in access
   assign pready      = 1'b1;
   assign pslverr     = psel && penable && !mapped;
   assign prdata      = st_reg.rdata;
   // In IR mode every main_out channel is gated by the small timer A carrier; small_b_out is not
   assign main_out    = st_reg.ctrl[CTRL_IR_EN] ? (st_reg.pwm & {NCH{sa_pwm}})
                                                 : st_reg.pwm;
   assign small_a_out = sa_pwm;
   assign small_b_out = sb_pwm;
   assign irq         = |(st_reg.stat & st_reg.mask);

   // The checks below watch registered state, including synchronizer and prescaler flops that software cannot read back
   a_main_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.mevt |-> st_reg.mcnt == '0 && $past(st_reg.mcnt) == $past(st_reg.mper))
      else $error("main counter did not wrap from period to zero");

   a_main_bound: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.ctrl[CTRL_MAIN_EN] && $past(st_reg.mcnt) <= $past(st_reg.mper)
      |-> st_reg.mcnt <= $past(st_reg.mper) || $changed(st_reg.mper))
      else $error("main counter ran past its period");

   a_pwm_level: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.ctrl[CTRL_MAIN_EN] && !st_reg.chmode[0] && $stable(st_reg.chval[0])
      && $stable(st_reg.chmode[0]) |-> st_reg.pwm[0] == (st_reg.mcnt < st_reg.chval[0]))
      else $error("channel 0 PWM level wrong for counter");

   a_ir_gate: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.ctrl[CTRL_IR_EN] && !sa_pwm |-> main_out == '0)
      else $error("IR output not gated by carrier");

   a_ir_count: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.ctrl[CTRL_IR_EN] && st_reg.ctrl[CTRL_MAIN_EN] && !sa_evt
      && $stable(st_reg.ctrl) ##1 $stable(st_reg.ctrl) |-> $stable(st_reg.mcnt))
      else $error("main counter moved without a small timer period in IR mode");

   a_cap_take: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.chmode[0] && st_reg.chedge[0][0] && st_reg.sync2[0] && !st_reg.sync3[0]
      && !(apb_wr && mapped) |=> st_reg.chval[0] == $past(st_reg.mcnt) && st_reg.stat[ST_CAP0])
      else $error("capture did not record counter on rising edge");

   a_cap_delay: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st_reg.stat[ST_CAP0]) |-> $past(st_reg.sync2[0]) != $past(st_reg.sync3[0]))
      else $error("capture status set without a synchronised edge");

   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq == |(st_reg.stat & st_reg.mask))
      else $error("interrupt level does not follow masked status");

   a_sa_event: assert property (@(posedge pclk) disable iff (!presetn)
      sa_evt |=> st_reg.stat[ST_SA])
      else $error("small timer A period event not latched");

   a_sb_event: assert property (@(posedge pclk) disable iff (!presetn)
      sb_evt |=> st_reg.stat[ST_SB])
      else $error("small timer B period event not latched");

   // Falling capture is watched on channel 1, rising capture on channel 0
   a_cap_fall: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.chmode[1] && st_reg.chedge[1][1] && !st_reg.sync2[1] && st_reg.sync3[1]
      && !(apb_wr && mapped)
      |=> st_reg.chval[1] == $past(st_reg.mcnt) && st_reg.stat[ST_CAP0 + 1])
      else $error("capture did not record counter on falling edge");

   a_cap_low: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.chmode[0] && $past(st_reg.chmode[0]) |-> !main_out[0])
      else $error("capture channel drives its output");

   a_pre_bound: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.ctrl[CTRL_MAIN_EN] && $stable(st_reg.mpre)
      && $past(st_reg.mpre_cnt) <= $past(st_reg.mpre) |-> st_reg.mpre_cnt <= st_reg.mpre)
      else $error("main prescaler ran past its setting");

   a_dis_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(st_reg.ctrl[CTRL_MAIN_EN]) |-> st_reg.mcnt == '0 && st_reg.mpre_cnt == '0)
      else $error("disabled main counter did not hold at zero");

   a_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      $past(st_reg.stat[ST_MAIN]) && !($past(apb_rd) && $past(paddr) == STAT_OFF)
      |-> st_reg.stat[ST_MAIN])
      else $error("main period status dropped without a status read");
endmodule : gpt_top
`default_nettype wire

// >>> test/gp_timers_ir_modulation_test.sv
// Self-checking bench for the timer group: APB master, PWM, period events, capture, IR mode
`timescale 1ns/10ps
`default_nettype none
module gp_timers_ir_modulation_test;
   import gpt_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        small_a_out, small_b_out, irq, run, er;
   logic [7:0]  paddr;
   logic [3:0]  pstrb;
   logic [31:0] pwdata, prdata, rd, m;
   logic [4:0]  cap_in, main_out;
   logic [2:0]  sel;
   logic [15:0] hi_cnt;
   int          n_mismatch, num_checks, cyc, pre, per, cmp, ch, w;

   gpt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cap_in(cap_in), .main_out(main_out),
      .small_a_out(small_a_out), .small_b_out(small_b_out), .irq(irq));
   gpt_pin_model PINS (.pclk(pclk), .cap_in(cap_in),
      .pins({small_b_out, small_a_out, main_out}), .sel(sel), .run(run), .hi_cnt(hi_cnt));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Cycle ceiling: a hung handshake or loop ends in the report as a mismatch
   always @(posedge pclk) begin
      cyc   <= cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      // Taken at the access edge, before that edge's register updates land
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Let the edge's updates settle before the caller looks at outputs
      #1;
      if (t >= 50) begin
         chk("pready", 32'h1, 32'h0);
      end
   endtask : apb

   task automatic measure(input int width, output int hi);
      @(posedge pclk);
      run <= 1'b1;
      repeat (width) @(posedge pclk);
      run <= 1'b0;
      #1;
      hi = hi_cnt;
   endtask : measure

   // High cycles over k periods: one tick lasts pr+1 clocks, a period pe+1 ticks
   function automatic int exp_hi(int pr, int pe, int cm, int k);
      return k * (pr + 1) * ((cm > pe) ? pe + 1 : cm);
   endfunction : exp_hi

   initial begin
      rd = $urandom(32'h1A202BD8);
      {presetn, psel, penable, pwrite, run} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      sel = 3'h0;
      cyc = 0;
      n_mismatch = 0;
      num_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, MPER_OFF, 32'h0);
      chk("main period reset", {16'h0, MPER_RST}, rd);
      apb(1'b0, SA_CFG_OFF, 32'h0);
      chk("small cfg reset", {16'h0, SPER_RST, PRE_RST}, rd & 32'h0000FFFF);
      apb(1'b0, 8'h3C, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, er});
      // Targets rotate main, A, B; compare zero, above period, then random
      for (int i = 0; i < 9; i++) begin
         pre = $urandom_range(3);
         per = $urandom_range(15, 1);
         cmp = (i < 3) ? 0 : (i < 6) ? per + 1 + i : $urandom_range(per, 1);
         ch  = $urandom_range(4);
         apb(1'b1, CTRL_OFF, 32'h0);
         if (i % 3 == 0) begin
            apb(1'b1, CHMODE_OFF, 32'h0);
            apb(1'b1, MPRE_OFF, pre);
            apb(1'b1, MPER_OFF, per);
            apb(1'b1, CHVAL_OFF + 8'(4 * ch), cmp);
            sel = 3'(ch);
         end else begin
            apb(1'b1, (i % 3 == 1) ? SA_CFG_OFF : SB_CFG_OFF,
                {8'h0, 8'(cmp), 8'(per), 8'(pre)});
            sel = 3'(4 + i % 3);
         end
         apb(1'b1, CTRL_OFF, 32'h1 << (i % 3));
         w = (pre + 1) * (per + 1);
         repeat (2 * w) @(posedge pclk);
         measure(3 * w, w);
         chk("pwm high cycles", exp_hi(pre, per, cmp, 3), w);
      end
      apb(1'b1, CTRL_OFF, 32'h0);
      apb(1'b1, MASK_OFF, 32'h0);
      apb(1'b1, MPRE_OFF, 32'h0);
      apb(1'b1, MPER_OFF, 32'h000000C7);
      apb(1'b0, STAT_OFF, 32'h0);
      apb(1'b1, CTRL_OFF, 32'h1);
      repeat (250) @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, MASK_OFF, 32'h1);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      apb(1'b0, STAT_OFF, 32'h0);
      chk("status main bit", 32'h1, {31'h0, rd[ST_MAIN]});
      chk("irq after clear", 32'h0, {31'h0, irq});
      // Rising on channel 0, falling on channel 1, then both edges on a random channel
      for (int e = 1; e <= 3; e++) begin
         ch = (e < 3) ? e - 1 : $urandom_range(4);
         apb(1'b1, CTRL_OFF, 32'h0);
         apb(1'b1, MPER_OFF, 32'h0000FFFF);
         apb(1'b1, CHMODE_OFF, (32'h1 << ch) | (32'(e) << (5 + 2 * ch)));
         apb(1'b1, CTRL_OFF, 32'h1);
         apb(1'b0, STAT_OFF, 32'h0);
         apb(1'b0, MCNT_OFF, 32'h0);
         m = rd;
         PINS.pulse(ch, $urandom_range(4, 2));
         repeat (4) @(posedge pclk);
         apb(1'b0, CHVAL_OFF + 8'(4 * ch), 32'h0);
         m = rd - m;
         chk("capture delay bounded", 32'h1, {31'h0, m > 0 && m < 40});
         apb(1'b0, STAT_OFF, 32'h0);
         chk("capture status", 32'h1, {31'h0, rd[ST_CAP0 + ch]});
      end
      apb(1'b1, CTRL_OFF, 32'h0);
      apb(1'b1, CHMODE_OFF, 32'h0);
      apb(1'b1, CHVAL_OFF, 32'h0000FFFF);
      apb(1'b1, SA_CFG_OFF, 32'h00020300);
      apb(1'b1, CTRL_OFF, 32'h0000000B);
      apb(1'b0, MCNT_OFF, 32'h0);
      m = rd;
      sel = 3'h0;
      measure(40, w);
      chk("ir carrier high cycles", 32'h14, w);
      apb(1'b0, MCNT_OFF, 32'h0);
      m = rd - m;
      chk("ir period count", 32'h1, {31'h0, m >= 9 && m <= 13});
      stop_test();
   end
endmodule : gp_timers_ir_modulation_test
`default_nettype wire

// >>> test/gpt_pin_model.sv
// Pin-side model: drives the capture pins and counts high cycles of one output pin
`timescale 1ns/10ps
`default_nettype none
module gpt_pin_model (
   input  wire logic       pclk,
   output logic [4:0]      cap_in,
   input  wire logic [6:0] pins,
   input  wire logic [2:0] sel,
   input  wire logic       run,
   output logic [15:0]     hi_cnt
);
   initial cap_in = 5'h00;
   always @(posedge pclk) begin
      if (!run) begin
         hi_cnt <= 16'h0000;
      end else if (pins[sel] === 1'b1) begin
         hi_cnt <= hi_cnt + 16'h0001;
      end
   end
   // Pulses last whole cycles, never under two, so the synchronizers cannot miss them
   task automatic pulse(input int ch, input int len);
      @(posedge pclk);
      cap_in[ch] <= 1'b1;
      repeat ((len < 2) ? 2 : len) @(posedge pclk);
      cap_in[ch] <= 1'b0;
   endtask : pulse
endmodule : gpt_pin_model
`default_nettype wire
